// [core/cmpc_top.sv]
// Mode straps, serial control port, line status interrupt and choppers
`timescale 1ns/1ps
// Operation
// - Host-interface strap low selects serial control mode, high GCI mode.
// - In GCI mode the serial input pin picks a 2.048 or 4.096 MHz clock.
// - Serial bytes program codec settings and line-interface outputs.
// - Serial out floats when deselected, shows line status, unused in GCI.
// - Compressed GCI: the slot pin picks timeslots 0-3 (low) or 4-7 (high).
// - Linear GCI: a low slot pin puts control in 0-3 and voice in 4-7.
// - A low reset pin returns the whole block to its default configuration.
// - One shared open-drain active-low interrupt flags line pin changes.
// - The slow chopper output has a programmable period of 2 to 28 ms.
// - The fast chopper output runs at 256 kHz, 512 kHz or 16.384 MHz.
// - Select low: compressed GCI or control port on; high: linear GCI.
// - Serial input is taken on rising edges, output changes on falling.
module cmpc_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	input wire logic i_host_interface_select,
	input wire logic i_chip_select_n,
	input wire logic i_control_clock_or_slot_select,
	input wire logic i_serial_in_or_rate_select,
	input wire logic [cmpc_pkg::SIG_W-1:0] i_line_status,
	output logic o_serial_control_out,
	output logic o_serial_control_out_oe,
	output logic o_int_n_out,
	output logic o_int_n_oe,
	output logic [cmpc_pkg::SIG_W-1:0] o_line_signal,
	output logic [cmpc_pkg::BYTE_W-1:0] o_codec_cfg,
	output cmpc_pkg::cmpc_mode_type o_mode,
	output logic o_slow_chopper_out,
	output logic o_fast_chopper_out
);
	import cmpc_pkg::*;

	typedef struct packed {
		logic [1:0] rst_s;
		logic [1:0] mpi_s;
		logic [1:0] cs_s;
		logic [1:0] ck_s;
		logic [1:0] di_s;
		logic [SIG_W-1:0] ls_s1;
		logic [SIG_W-1:0] ls_s2;
		logic [SIG_W-1:0] ls_prev;
		logic ck_prev;
		logic strap_armed;
		cmpc_mode_type mode;
		cmpc_state_type fsm;
		logic [BITCNT_W-1:0] bit_cnt;
		logic [BYTE_W-1:0] sh_in;
		logic [BYTE_W-1:0] cmd;
		logic [BYTE_W-1:0] sh_out;
		logic so;
		logic so_oe;
		logic [SIG_W-1:0] pend;
		logic int_n_oe;
		logic [SIG_W-1:0] line_sig;
		logic [BYTE_W-1:0] codec_cfg;
		cmpc_chop_cfg_type chop;
	} cmpc_top_state_type;

	cmpc_top_state_type st_r, st_nxt;
	logic dev_rst;
	logic ck_rise;
	logic ck_fall;
	logic byte_done;
	logic [BYTE_W-1:0] byte_in;
	logic [SIG_W-1:0] ls_change;

	// Synchronous combined reset; pin reset is synchronised first
	assign dev_rst = i_rst | ~st_r.rst_s[1];

	always_comb begin
		st_nxt = st_r;
		st_nxt.rst_s = {st_r.rst_s[0], i_reset_n};
		st_nxt.mpi_s = {st_r.mpi_s[0], i_host_interface_select};
		st_nxt.cs_s = {st_r.cs_s[0], i_chip_select_n};
		st_nxt.ck_s = {st_r.ck_s[0], i_control_clock_or_slot_select};
		st_nxt.di_s = {st_r.di_s[0], i_serial_in_or_rate_select};
		st_nxt.ls_s1 = i_line_status;
		st_nxt.ls_s2 = st_r.ls_s1;
		st_nxt.ls_prev = st_r.ls_s2;
		st_nxt.ck_prev = st_r.ck_s[1];
		ck_rise = st_r.ck_s[1] & ~st_r.ck_prev;
		ck_fall = ~st_r.ck_s[1] & st_r.ck_prev;
		byte_in = {st_r.sh_in[BYTE_W-2:0], st_r.di_s[1]};
		byte_done = 1'b0;
		ls_change = st_r.ls_s2 ^ st_r.ls_prev;

		// Straps latched once, after reset release
		if (st_r.strap_armed) begin
			st_nxt.strap_armed = 1'b0;
			st_nxt.mode.gci_mode = st_r.mpi_s[1];
			// In control mode these pins are the serial port, not straps
			st_nxt.mode.rate_double = st_r.mpi_s[1] & st_r.di_s[1];
			st_nxt.mode.slot_high = st_r.mpi_s[1] & st_r.ck_s[1];
			st_nxt.mode.linear = st_r.mpi_s[1] & st_r.cs_s[1];
		end

		// Serial control port, active only in control mode with select low
		if (!st_r.mode.gci_mode && !st_r.strap_armed && !st_r.cs_s[1]) begin
			if (ck_rise) begin
				st_nxt.sh_in = byte_in;
				st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
				byte_done = (st_r.bit_cnt == BIT_LAST);
			end
			if (ck_fall && st_r.fsm == CMPC_ST_READ) begin
				st_nxt.so = st_r.sh_out[BYTE_W-1];
				st_nxt.sh_out = {st_r.sh_out[BYTE_W-2:0], 1'b0};
			end
			st_nxt.so_oe = 1'b1;
			case (st_r.fsm)
			CMPC_ST_CMD: begin
				if (byte_done && byte_in[CMD_RD_BIT]) begin
					// Status read: new commands ignored until select rises
					st_nxt.fsm = CMPC_ST_READ;
					st_nxt.sh_out = st_r.ls_s2;
					st_nxt.pend = ls_change;
				end else if (byte_done) begin
					st_nxt.cmd = byte_in;
					st_nxt.fsm = CMPC_ST_DATA;
				end
			end
			CMPC_ST_DATA: begin
				if (byte_done) begin
					st_nxt.fsm = CMPC_ST_CMD;
					case (st_r.cmd[CMD_OP_HI:CMD_OP_LO])
					OP_CODEC: st_nxt.codec_cfg = byte_in;
					OP_LINE: st_nxt.line_sig = byte_in;
					OP_CHOP: st_nxt.chop = cmpc_chop_cfg_type'(
						byte_in[SLOW_SEL_W+1:0]);
					default: st_nxt.codec_cfg = st_r.codec_cfg;
					endcase
				end
			end
			CMPC_ST_READ: st_nxt.fsm = CMPC_ST_READ;
			default: st_nxt.fsm = CMPC_ST_CMD;
			endcase
		end else begin
			// Select high aborts any transfer and floats the output
			st_nxt.so_oe = 1'b0;
			st_nxt.so = 1'b0;
			st_nxt.bit_cnt = '0;
			st_nxt.fsm = CMPC_ST_CMD;
		end

		// Change sets win over the clearing read
		if (!(st_r.fsm == CMPC_ST_CMD && byte_done && byte_in[CMD_RD_BIT]))
			st_nxt.pend = st_r.pend | ls_change;
		st_nxt.int_n_oe = (st_nxt.pend != '0);
	end

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			st_r <= '0;
			st_r.rst_s <= {1'b0, st_nxt.rst_s[0]};
			st_r.strap_armed <= 1'b1;
			st_r.fsm <= CMPC_ST_CMD;
			st_r.line_sig <= SIG_RESET;
			st_r.pend <= ST_RESET;
			st_r.chop.slow_sel <= SLOW_SEL_MIN;
			st_r.chop.fast_sel <= FAST_SEL_RESET;
			// Synchronisers keep running: straps are valid when the
			// reset ends and no false clock edge follows it
			st_r.mpi_s <= st_nxt.mpi_s;
			st_r.cs_s <= st_nxt.cs_s;
			st_r.ck_s <= st_nxt.ck_s;
			st_r.di_s <= st_nxt.di_s;
			st_r.ck_prev <= st_nxt.ck_prev;
			st_r.ls_s1 <= st_nxt.ls_s1;
			st_r.ls_s2 <= st_nxt.ls_s2;
			st_r.ls_prev <= st_nxt.ls_prev;
			if (!i_rst)
				st_r.rst_s <= st_nxt.rst_s;
		end else begin
			st_r <= st_nxt;
		end
	end

	cmpc_chopper u_chopper (
		.i_clk(i_clk),
		.i_rst(dev_rst),
		.i_cfg(st_r.chop),
		.o_slow(o_slow_chopper_out),
		.o_fast(o_fast_chopper_out)
	);

	assign o_serial_control_out = st_r.so;
	assign o_serial_control_out_oe = st_r.so_oe;
	assign o_int_n_out = 1'b0;
	assign o_int_n_oe = st_r.int_n_oe;
	assign o_line_signal = st_r.line_sig;
	assign o_codec_cfg = st_r.codec_cfg;
	assign o_mode = st_r.mode;

	a_out_floats: assert property (@(posedge i_clk)
		disable iff (dev_rst) st_r.cs_s[1] |=> !o_serial_control_out_oe)
		else $error("serial out driven while deselected");
	a_gci_no_out: assert property (@(posedge i_clk)
		disable iff (dev_rst) o_mode.gci_mode |-> !o_serial_control_out_oe)
		else $error("serial out driven in GCI mode");
	a_mode_static: assert property (@(posedge i_clk)
		disable iff (dev_rst) !st_r.strap_armed |=> $stable(o_mode))
		else $error("mode changed without reset");
	a_strap_taken: assert property (@(posedge i_clk)
		disable iff (dev_rst) st_r.strap_armed
		|=> (o_mode.gci_mode == $past(st_r.mpi_s[1]))
		&& (o_mode.rate_double == ($past(st_r.mpi_s[1])
		& $past(st_r.di_s[1]))))
		else $error("strap not captured");
	a_slot_taken: assert property (@(posedge i_clk)
		disable iff (dev_rst) st_r.strap_armed
		|=> (o_mode.slot_high == ($past(st_r.mpi_s[1])
		& $past(st_r.ck_s[1])))
		&& (o_mode.linear == ($past(st_r.mpi_s[1]) & $past(st_r.cs_s[1]))))
		else $error("slot or format strap not captured");
	a_int_on_change: assert property (@(posedge i_clk)
		disable iff (dev_rst) (ls_change != '0) |=> o_int_n_oe)
		else $error("line change without interrupt");
	// Only a status read command may let the interrupt go
	a_int_holds: assert property (@(posedge i_clk)
		disable iff (dev_rst) (o_int_n_oe && !(st_r.fsm == CMPC_ST_CMD
		&& byte_done && byte_in[CMD_RD_BIT])) |=> o_int_n_oe)
		else $error("interrupt dropped without read");
	a_out_on_fall: assert property (@(posedge i_clk)
		disable iff (dev_rst)
		(!ck_fall && st_r.fsm == CMPC_ST_READ && !st_r.cs_s[1])
		|=> $stable(o_serial_control_out))
		else $error("serial out changed off falling edge");
	a_line_write: assert property (@(posedge i_clk)
		disable iff (dev_rst)
		(st_r.fsm == CMPC_ST_DATA && byte_done && !st_r.cs_s[1]
		&& st_r.cmd[CMD_OP_HI:CMD_OP_LO] == OP_LINE)
		|=> (o_line_signal == $past(byte_in)))
		else $error("line signal write lost");
	a_reset_defaults: assert property (@(posedge i_clk)
		dev_rst |=> (o_line_signal == SIG_RESET) && !o_int_n_oe)
		else $error("reset did not restore defaults");
	c_gci_mode: cover property (@(posedge i_clk) o_mode.gci_mode);
	c_read: cover property (@(posedge i_clk) st_r.fsm == CMPC_ST_READ);
	c_write: cover property (@(posedge i_clk)
		st_r.fsm == CMPC_ST_DATA && byte_done);
	c_interrupt: cover property (@(posedge i_clk) $rose(o_int_n_oe));
endmodule

// [shared/cmpc_pkg.sv]
// Shared constants and types for the codec mode and pin control block
package cmpc_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	// Chopper timing, printed units
	localparam int SLOW_MIN_MS = 2;
	localparam int SLOW_MAX_MS = 28;
	localparam int FAST_256_KHZ = 256;
	localparam int FAST_512_KHZ = 512;
	localparam int FAST_16M_KHZ = 16384;
	localparam int CLK_KHZ = 250000;
	// Half periods in clock cycles (each rounds down, the shortest at least 1)
	localparam int SLOW_HALF_PER_MS = CLK_KHZ / 2;
	localparam int FAST_HALF_256 = CLK_KHZ / (2 * FAST_256_KHZ);
	localparam int FAST_HALF_512 = CLK_KHZ / (2 * FAST_512_KHZ);
	localparam int FAST_HALF_16M = (CLK_KHZ / (2 * FAST_16M_KHZ) < 1) ? 1 :
		CLK_KHZ / (2 * FAST_16M_KHZ);
	localparam int CNT_W = 24;
	localparam int SLOW_SEL_W = 5;
	localparam logic [SLOW_SEL_W-1:0] SLOW_SEL_MIN = 5'h02;
	localparam logic [SLOW_SEL_W-1:0] SLOW_SEL_MAX = 5'h1C;
	localparam int BYTE_W = 8;
	localparam int BITCNT_W = 3;
	localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7;
	localparam int SIG_W = 8;
	localparam logic [SIG_W-1:0] SIG_RESET = 8'h00;
	localparam logic [SIG_W-1:0] ST_RESET = 8'h00;
	// Command byte layout: bit 7 set means read line status
	localparam int CMD_RD_BIT = 7;
	localparam int CMD_OP_HI = 6;
	localparam int CMD_OP_LO = 5;
	localparam logic [1:0] OP_CODEC = 2'h0;
	localparam logic [1:0] OP_LINE = 2'h1;
	localparam logic [1:0] OP_CHOP = 2'h2;
	localparam logic [1:0] FAST_SEL_256 = 2'h0;
	localparam logic [1:0] FAST_SEL_512 = 2'h1;
	localparam logic [1:0] FAST_SEL_16M = 2'h2;
	localparam logic [1:0] FAST_SEL_RESET = 2'h0;

	typedef enum logic [1:0] {
		CMPC_ST_CMD = 2'h0,
		CMPC_ST_DATA = 2'h1,
		CMPC_ST_READ = 2'h3
	} cmpc_state_type;

	typedef struct packed {
		logic gci_mode;
		logic rate_double;
		logic slot_high;
		logic linear;
	} cmpc_mode_type;

	typedef struct packed {
		logic [SLOW_SEL_W-1:0] slow_sel;
		logic [1:0] fast_sel;
	} cmpc_chop_cfg_type;
endpackage

// [core/cmpc_chopper.sv]
// Chopper clock generator: slow ms-period and fast selectable output
`timescale 1ns/1ps
module cmpc_chopper (
	input wire logic i_clk,
	input wire logic i_rst,
	input cmpc_pkg::cmpc_chop_cfg_type i_cfg,
	output logic o_slow,
	output logic o_fast
);
	import cmpc_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] slow_cnt;
		logic [SLOW_SEL_W-1:0] ms_cnt;
		logic [CNT_W-1:0] fast_cnt;
		logic slow;
		logic fast;
	} cmpc_chop_state_type;

	cmpc_chop_state_type st_r, st_nxt;
	logic [SLOW_SEL_W-1:0] half_ms;
	logic [CNT_W-1:0] fast_half;

	always_comb begin
		st_nxt = st_r;
		// Period in ms is slow_sel; each half lasts slow_sel/2 ms
		half_ms = (i_cfg.slow_sel < SLOW_SEL_MIN) ? SLOW_SEL_MIN :
			(i_cfg.slow_sel > SLOW_SEL_MAX) ? SLOW_SEL_MAX : i_cfg.slow_sel;
		case (i_cfg.fast_sel)
		FAST_SEL_512: fast_half = CNT_W'(FAST_HALF_512);
		FAST_SEL_16M: fast_half = CNT_W'(FAST_HALF_16M);
		default: fast_half = CNT_W'(FAST_HALF_256);
		endcase
		// Count half-ms ticks; toggle after slow_sel of them
		if (st_r.slow_cnt >= CNT_W'(SLOW_HALF_PER_MS - 1)) begin
			st_nxt.slow_cnt = '0;
			if (st_r.ms_cnt + 5'h01 >= half_ms) begin
				st_nxt.ms_cnt = '0;
				st_nxt.slow = ~st_r.slow;
			end else begin
				st_nxt.ms_cnt = st_r.ms_cnt + 5'h01;
			end
		end else begin
			st_nxt.slow_cnt = st_r.slow_cnt + 24'h000001;
		end
		// Fast output toggles every fast_half cycles
		if (st_r.fast_cnt + 24'h000001 >= fast_half) begin
			st_nxt.fast_cnt = '0;
			st_nxt.fast = ~st_r.fast;
		end else begin
			st_nxt.fast_cnt = st_r.fast_cnt + 24'h000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_slow = st_r.slow;
	assign o_fast = st_r.fast;

	a_fast_toggle: assert property (@(posedge i_clk)
		disable iff (i_rst) (st_r.fast_cnt + 24'h000001 >= fast_half)
		|=> (o_fast != $past(o_fast)))
		else $error("fast chopper missed its toggle");
	// Only the last cycle of a half-ms tick may move the slow output
	a_slow_steady: assert property (@(posedge i_clk)
		disable iff (i_rst)
		(st_r.slow_cnt != CNT_W'(SLOW_HALF_PER_MS - 1)) |=> $stable(o_slow))
		else $error("slow chopper toggled mid tick");
	c_fast_toggles: cover property (@(posedge i_clk) $rose(o_fast));
endmodule

// [verif/cmpc_host_model.sv]
// Host model for the serial control port: clock, select, data in and out
`timescale 1ns/1ps
module cmpc_host_model (
	input wire logic i_clk,
	input wire logic i_so,
	input wire logic i_so_oe,
	output logic o_cclk,
	output logic o_cs_n,
	output logic o_si
);
	logic last_so = 1'b0;
	logic seen_so;
	// A floating output shows the inverse of its last level, never a kind guess
	assign seen_so = i_so_oe ? i_so : ~last_so;
	always @(posedge i_clk) begin
		if (i_so_oe) begin
			last_so <= i_so;
		end
	end
	initial begin
		o_cclk = 1'b1;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Data line is flipped when released so stale bits cannot pass
	task automatic sel(input logic v);
		o_cs_n = v;
		if (v) begin
			o_si = ~o_si;
		end
		tick(20);
	endtask
	// 20 cycle phases make a 160 ns clock; it stands high between frames
	task automatic xfer(input logic [7:0] d, input int n,
		output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < n; i++) begin
			o_cclk = 1'b0;
			o_si = d[7-i];
			tick(20);
			o_cclk = 1'b1;
			q[7-i] = seen_so;
			tick(20);
		end
	endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the mode strap and serial control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("[ERR] %s exp %0h got %0h", nm, exp, got); \
	end \
end
module tb_top;
	import cmpc_pkg::*;
	logic i_clk;
	logic i_rst;
	logic i_reset_n;
	logic st_host, st_cs, st_slot, st_rate;
	logic [SIG_W-1:0] line_st;
	logic cclk, cs_n, si, so, so_oe, int_out, int_oe, slow, fast;
	logic [SIG_W-1:0] line_sig;
	logic [BYTE_W-1:0] codec;
	cmpc_mode_type mode;
	logic [7:0] q;
	logic pin_cs;
	logic pin_ck;
	logic pin_di;
	// Dual-purpose pins carry straps in GCI mode, the serial port otherwise
	assign pin_cs = st_host ? st_cs : cs_n;
	assign pin_ck = st_host ? st_slot : cclk;
	assign pin_di = st_host ? st_rate : si;
	int error_cnt = 0;
	int cmp_count = 0;

	cmpc_host_model hp (
		.i_clk(i_clk),
		.i_so(so),
		.i_so_oe(so_oe),
		.o_cclk(cclk),
		.o_cs_n(cs_n),
		.o_si(si)
	);
	cmpc_top uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_reset_n(i_reset_n),
		.i_host_interface_select(st_host),
		.i_chip_select_n(pin_cs),
		.i_control_clock_or_slot_select(pin_ck),
		.i_serial_in_or_rate_select(pin_di),
		.i_line_status(line_st),
		.o_serial_control_out(so),
		.o_serial_control_out_oe(so_oe),
		.o_int_n_out(int_out),
		.o_int_n_oe(int_oe),
		.o_line_signal(line_sig),
		.o_codec_cfg(codec),
		.o_mode(mode),
		.o_slow_chopper_out(slow),
		.o_fast_chopper_out(fast)
	);

	initial begin
		i_clk = 1'b0;
		// Block clock oversamples every pin and master clock rate
		forever #2 i_clk = ~i_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		hp.sel(1'b0);
		hp.xfer(c, 8, q);
		hp.xfer(d, 8, q);
		hp.sel(1'b1);
	endtask
	task automatic pulse_rst;
		i_rst = 1'b1;
		tick(2);
		i_rst = 1'b0;
		tick(5);
	endtask

	task automatic t_reset;
		`CHK("line sig", 8'h00, line_sig)
		`CHK("codec", 8'h00, codec)
		`CHK("mode", 4'h0, mode)
		`CHK("so oe", 1'b0, so_oe)
		`CHK("int oe", 1'b0, int_oe)
	endtask
	task automatic t_write;
		wr(8'h20, 8'h5A);
		`CHK("line sig", 8'h5A, line_sig)
		wr(8'h00, 8'hC3);
		`CHK("codec", 8'hC3, codec)
		`CHK("so oe", 1'b0, so_oe)
		// Half a byte then deselect: the bit count must restart
		hp.sel(1'b0);
		hp.xfer(8'h20, 4, q);
		hp.sel(1'b1);
		wr(8'h20, 8'h33);
		`CHK("line abort", 8'h33, line_sig)
		i_reset_n = 1'b0;
		tick(5);
		`CHK("pin reset line", 8'h00, line_sig)
		`CHK("pin reset codec", 8'h00, codec)
		i_reset_n = 1'b1;
		tick(8);
	endtask
	task automatic t_irq;
		line_st = 8'h81;
		tick(100);
		`CHK("int oe", 1'b1, int_oe)
		`CHK("int level", 1'b0, int_out)
		hp.sel(1'b0);
		hp.xfer(8'h80, 8, q);
		hp.xfer(8'h00, 8, q);
		hp.sel(1'b1);
		`CHK("status", 8'h81, q)
		`CHK("int clear", 1'b0, int_oe)
		`CHK("so float", 1'b0, so_oe)
	endtask
	task automatic t_chop;
		int half[3] = '{FAST_HALF_256, FAST_HALF_512, FAST_HALF_16M};
		int n;
		logic v;
		for (int k = 0; k < 3; k++) begin
			wr(8'h40, {1'b0, 5'h02, k[1:0]});
			for (int e = 0; e < 2; e++) begin
				v = fast;
				n = 0;
				while (fast === v && n < 2000) begin
					tick(1);
					n++;
				end
			end
			`CHK("fast half", half[k], n)
		end
		// Shortest slow half period is longer than the whole run
		`CHK("slow idle", 1'b0, slow)
	endtask
	task automatic t_gci;
		st_host = 1'b1;
		st_rate = 1'b1;
		st_slot = 1'b1;
		st_cs = 1'b1;
		pulse_rst();
		`CHK("mode gci", 4'hF, mode)
		st_rate = 1'b0;
		st_slot = 1'b0;
		st_cs = 1'b0;
		pulse_rst();
		`CHK("mode gci", 4'h8, mode)
		`CHK("so gci", 1'b0, so_oe)
		// Strap moved without reset must not reach the mode outputs
		st_host = 1'b0;
		tick(10);
		`CHK("mode held", 4'h8, mode)
		pulse_rst();
		`CHK("mode mpi", 4'h0, mode)
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		i_rst = 1'b1;
		i_reset_n = 1'b1;
		st_host = 1'b0;
		st_cs = 1'b1;
		st_slot = 1'b0;
		st_rate = 1'b0;
		line_st = 8'h00;
		tick(20);
		i_rst = 1'b0;
		tick(5);
		t_reset();
		t_write();
		t_irq();
		t_chop();
		t_gci();
		close_out();
	end

	// Whole run needs about 6600 cycles; nine times that means a hang
	initial begin
		repeat (60000) @(posedge i_clk);
		error_cnt++;
		close_out();
	end
endmodule
